// >>> verilog/t2c_pkg.sv
// Constants shared by the 16-bit capture/reload timer block.
// Assumes an 8-bit register port and one 50 MHz system clock.
package t2c_pkg;

  // Register offsets on the 8-bit register port
  localparam logic [7:0] OFS_CTRL     = 8'hC8;
  localparam logic [7:0] OFS_MODE     = 8'hC9;
  localparam logic [7:0] OFS_RCAP_LO  = 8'hCA;
  localparam logic [7:0] OFS_RCAP_HI  = 8'hCB;
  localparam logic [7:0] OFS_CNT_LO   = 8'hCC;
  localparam logic [7:0] OFS_CNT_HI   = 8'hCD;
  localparam logic [7:0] OFS_CLK_SEL  = 8'hDF;
  localparam logic [7:0] OFS_IRQ_STAT = 8'hC0;
  localparam logic [7:0] OFS_IRQ_MASK = 8'hC1;

  // Control register bit positions
  localparam int CTRL_OVF_FLAG  = 7;
  localparam int CTRL_EXT_FLAG  = 6;
  localparam int CTRL_RX_BAUD   = 5;
  localparam int CTRL_TX_BAUD   = 4;
  localparam int CTRL_EXT_EN    = 3;
  localparam int CTRL_RUN       = 2;
  localparam int CTRL_CNT_SRC   = 1;
  localparam int CTRL_CAP_SEL   = 0;

  // Mode register bit positions and writable mask
  localparam int MODE_CLK_OUT_EN = 1;
  localparam int MODE_DOWN_EN    = 0;
  localparam logic [7:0] MODE_MASK = 8'h03;

  // Clock select register: tick divider bit, writable mask
  localparam int CLK_SEL_DIV     = 5;
  localparam logic [7:0] CLK_SEL_MASK = 8'h39;

  // Interrupt status and mask bit positions
  localparam int IRQ_OVF = 0;
  localparam int IRQ_EXT = 1;

  // Reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [1:0]  RST_IRQ  = 2'h0;

  // Tick divider ratios of the system clock
  localparam logic [3:0] DIV_FAST = 4'h6;
  localparam logic [3:0] DIV_SLOW = 4'hC;

  // Counter extremes
  localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO     = 16'h0000;

endpackage

// >>> verilog/t2c_timer.sv
// 16-bit timer/counter with capture, auto-reload, up/down and clock-out.
// Assumes a synchronous register port and a trigger pin already in the
// clock domain; read data appear the cycle after the read strobe.
//
// Contract
// - Run bit high advances the counter; low holds both count bytes except for a pin-triggered reload.
// - Source bit 0 ticks from divided clock; 1 counts trigger pin falls.
// - Edge enable with select 0 reloads on overflow and on pin fall.
// - Edge enable with select 1 captures counter on each pin fall.
// - Either baud bit forces auto-reload, ignoring the capture select.
// - Clock-out enable, mode bit 1, switches the clock-out output.
// - Down enable in auto-reload lets pin level set count direction.
// - Capture loads counter low byte into low reload/capture register.
// - Capture loads counter high byte into high reload/capture register.
// - Auto-reload value is high and low reload registers as one word.
// - Counter low and high bytes sit at consecutive readable addresses.
// - Divider bit 5 picks clock divided by 6 at 0, 12 at 1.
// - Twelve-clock option makes the divider bit ineffective.
// - Outside baud mode and with down count off, enabled pin fall triggers capture or reload.
// - Enabled pin fall sets external flag outside baud mode and when down count off.
// - Overflow flag set on overflow or down match, baud bits both 0.
// - Baud bits route overflow as serial receive or transmit time base.
`timescale 1ns/1ps
`default_nettype none

module t2c_timer
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output var  logic [7:0] rdata_out,
  input  wire logic       ext_trigger_pin_in,
  input  wire logic       opt_twelve_clk_in,
  output var  logic       clock_out_out,
  output var  logic       baud_rx_tick_out,
  output var  logic       baud_tx_tick_out,
  output var  logic       irq_out
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] rcap_lo;
    logic [7:0] rcap_hi;
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    logic [7:0] clk_sel;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [3:0] presc;
    logic       pin_prev;
    logic [7:0] rdata;
    logic       irq;
    logic       clk_out;
    logic       baud_rx;
    logic       baud_tx;
  } t2c_state_type;

  t2c_state_type s_r;
  t2c_state_type s_nxt;

  // Next-state logic for counter, flags and register port
  always_comb
  begin
    logic        baud;
    logic        cap_mode;
    logic        down_mode;
    logic        fall;
    logic        ptick;
    logic        tick;
    logic        up;
    logic        ovf;
    logic        ext_ev;
    logic [3:0]  div_last;
    logic [15:0] cnt;
    logic [15:0] rcap;
    logic [1:0]  ev;
    baud      = 1'b0;
    cap_mode  = 1'b0;
    down_mode = 1'b0;
    fall      = 1'b0;
    ptick     = 1'b0;
    tick      = 1'b0;
    up        = 1'b1;
    ovf       = 1'b0;
    ext_ev    = 1'b0;
    div_last  = 4'h0;
    cnt       = 16'h0000;
    rcap      = 16'h0000;
    ev        = 2'h0;
    s_nxt     = s_r;

    baud = s_r.ctrl[t2c_pkg::CTRL_RX_BAUD] | s_r.ctrl[t2c_pkg::CTRL_TX_BAUD];
    // Baud mode overrides the capture select
    cap_mode = s_r.ctrl[t2c_pkg::CTRL_CAP_SEL] & ~baud;
    down_mode = s_r.mode[t2c_pkg::MODE_DOWN_EN] & ~cap_mode;
    cnt  = {s_r.cnt_hi, s_r.cnt_lo};
    rcap = {s_r.rcap_hi, s_r.rcap_lo};

    // Falling edge of the trigger pin
    fall = s_r.pin_prev & ~ext_trigger_pin_in;
    s_nxt.pin_prev = ext_trigger_pin_in;

    // Prescaler: divide by 6 or 12, twelve-clock option forces 12
    if (opt_twelve_clk_in | s_r.clk_sel[t2c_pkg::CLK_SEL_DIV])
      div_last = t2c_pkg::DIV_SLOW - 4'h1;
    else
      div_last = t2c_pkg::DIV_FAST - 4'h1;
    if (s_r.presc >= div_last)
    begin
      s_nxt.presc = 4'h0;
      ptick = 1'b1;
    end
    else
      s_nxt.presc = s_r.presc + 4'h1;

    // Tick source and run gate
    tick = s_r.ctrl[t2c_pkg::CTRL_RUN] &
           (s_r.ctrl[t2c_pkg::CTRL_CNT_SRC] ? fall : ptick);

    // Direction from pin level when down counting in reload mode
    up = ~down_mode | ext_trigger_pin_in;
    ovf = tick & (up ? (cnt == t2c_pkg::CNT_ALL_ONES) : (cnt == rcap));

    // Pin trigger outside baud mode; pin is direction when down counting
    ext_ev = fall & s_r.ctrl[t2c_pkg::CTRL_EXT_EN] & ~baud &
             ~down_mode;

    // Counter update
    if (tick)
    begin
      if (ovf)
      begin
        if (!up)
          cnt = t2c_pkg::CNT_ALL_ONES;
        else if (cap_mode)
          cnt = t2c_pkg::CNT_ZERO;
        else
          cnt = rcap;
      end
      else if (up)
        cnt = cnt + 16'h0001;
      else
        cnt = cnt - 16'h0001;
    end
    // Pin-triggered reload or capture of the present count
    if (ext_ev && !cap_mode)
      cnt = rcap;
    if (ext_ev && cap_mode)
    begin
      s_nxt.rcap_lo = s_r.cnt_lo;
      s_nxt.rcap_hi = s_r.cnt_hi;
    end
    s_nxt.cnt_lo = cnt[7:0];
    s_nxt.cnt_hi = cnt[15:8];

    // Hardware flag events
    ev[t2c_pkg::IRQ_OVF] = ovf & ~baud;
    ev[t2c_pkg::IRQ_EXT] = ext_ev;
    s_nxt.ctrl[t2c_pkg::CTRL_OVF_FLAG] =
      s_r.ctrl[t2c_pkg::CTRL_OVF_FLAG] | ev[t2c_pkg::IRQ_OVF];
    s_nxt.ctrl[t2c_pkg::CTRL_EXT_FLAG] =
      s_r.ctrl[t2c_pkg::CTRL_EXT_FLAG] | ev[t2c_pkg::IRQ_EXT];

    // Register writes; software write overrides count, flag set wins
    if (wr_in)
    begin
      case (addr_in)
        t2c_pkg::OFS_CTRL:
        begin
          s_nxt.ctrl = wdata_in;
          s_nxt.ctrl[t2c_pkg::CTRL_OVF_FLAG] =
            wdata_in[t2c_pkg::CTRL_OVF_FLAG] | ev[t2c_pkg::IRQ_OVF];
          s_nxt.ctrl[t2c_pkg::CTRL_EXT_FLAG] =
            wdata_in[t2c_pkg::CTRL_EXT_FLAG] | ev[t2c_pkg::IRQ_EXT];
        end
        t2c_pkg::OFS_MODE:     s_nxt.mode = wdata_in & t2c_pkg::MODE_MASK;
        t2c_pkg::OFS_RCAP_LO:  s_nxt.rcap_lo = wdata_in;
        t2c_pkg::OFS_RCAP_HI:  s_nxt.rcap_hi = wdata_in;
        t2c_pkg::OFS_CNT_LO:   s_nxt.cnt_lo = wdata_in;
        t2c_pkg::OFS_CNT_HI:   s_nxt.cnt_hi = wdata_in;
        t2c_pkg::OFS_CLK_SEL:
          s_nxt.clk_sel = wdata_in & t2c_pkg::CLK_SEL_MASK;
        t2c_pkg::OFS_IRQ_MASK: s_nxt.irq_mask = wdata_in[1:0];
        default:               s_nxt.irq_mask = s_r.irq_mask;
      endcase
    end

    // Sticky status, write one to clear, set wins
    if (wr_in && addr_in == t2c_pkg::OFS_IRQ_STAT)
      s_nxt.irq_stat = (s_r.irq_stat & ~wdata_in[1:0]) | ev;
    else
      s_nxt.irq_stat = s_r.irq_stat | ev;
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);

    // Clock-out toggles on each overflow while enabled
    if (!s_r.mode[t2c_pkg::MODE_CLK_OUT_EN])
      s_nxt.clk_out = 1'b0;
    else if (ovf)
      s_nxt.clk_out = ~s_r.clk_out;

    // Overflow pulses as serial time base
    s_nxt.baud_rx = ovf & s_r.ctrl[t2c_pkg::CTRL_RX_BAUD];
    s_nxt.baud_tx = ovf & s_r.ctrl[t2c_pkg::CTRL_TX_BAUD];

    // Read data one cycle after the strobe, unmapped reads zero
    s_nxt.rdata = 8'h00;
    if (rd_in)
    begin
      case (addr_in)
        t2c_pkg::OFS_CTRL:     s_nxt.rdata = s_r.ctrl;
        t2c_pkg::OFS_MODE:     s_nxt.rdata = s_r.mode;
        t2c_pkg::OFS_RCAP_LO:  s_nxt.rdata = s_r.rcap_lo;
        t2c_pkg::OFS_RCAP_HI:  s_nxt.rdata = s_r.rcap_hi;
        t2c_pkg::OFS_CNT_LO:   s_nxt.rdata = s_r.cnt_lo;
        t2c_pkg::OFS_CNT_HI:   s_nxt.rdata = s_r.cnt_hi;
        t2c_pkg::OFS_CLK_SEL:  s_nxt.rdata = s_r.clk_sel;
        t2c_pkg::OFS_IRQ_STAT: s_nxt.rdata = {6'h00, s_r.irq_stat};
        t2c_pkg::OFS_IRQ_MASK: s_nxt.rdata = {6'h00, s_r.irq_mask};
        default:               s_nxt.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_r.ctrl     <= t2c_pkg::RST_BYTE;
      s_r.mode     <= t2c_pkg::RST_BYTE;
      s_r.rcap_lo  <= t2c_pkg::RST_BYTE;
      s_r.rcap_hi  <= t2c_pkg::RST_BYTE;
      s_r.cnt_lo   <= t2c_pkg::RST_BYTE;
      s_r.cnt_hi   <= t2c_pkg::RST_BYTE;
      s_r.clk_sel  <= t2c_pkg::RST_BYTE;
      s_r.irq_stat <= t2c_pkg::RST_IRQ;
      s_r.irq_mask <= t2c_pkg::RST_IRQ;
      s_r.presc    <= 4'h0;
      s_r.pin_prev <= 1'b1;
      s_r.rdata    <= t2c_pkg::RST_BYTE;
      s_r.irq      <= 1'b0;
      s_r.clk_out  <= 1'b0;
      s_r.baud_rx  <= 1'b0;
      s_r.baud_tx  <= 1'b0;
    end
    else
      s_r <= s_nxt;
  end

  // Outputs straight from flip-flops
  assign rdata_out        = s_r.rdata;
  assign clock_out_out    = s_r.clk_out;
  assign baud_rx_tick_out = s_r.baud_rx;
  assign baud_tx_tick_out = s_r.baud_tx;
  assign irq_out          = s_r.irq;

endmodule

`default_nettype wire

// >>> tb/t2c_trig_model.sv
// Trigger pin source outside the timer.
// Assumes the bench pulses fall_in for one cycle for each edge wanted.
`timescale 1ns/1ps
`default_nettype none
module t2c_trig_model
(
  input  wire logic clk_in,
  input  wire logic fall_in,
  output wire logic pin_out
);
  logic [1:0] low_r = 2'h0;
  // Pin idles high and drops low for two cycles per request
  always @(posedge clk_in)
  begin
    if (fall_in)
      low_r <= 2'h2;
    else if (low_r != 2'h0)
      low_r <= low_r - 2'h1;
  end
  assign pin_out = (low_r == 2'h0);
endmodule
`default_nettype wire

// >>> tb/t2c_timer_asserts.sv
// Port checks for the capture/reload timer.
// Assumes it is bound to t2c_timer and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module t2c_timer_asserts
(
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       clock_out_out,
  input wire logic       baud_rx_tick_out,
  input wire logic       baud_tx_tick_out,
  input wire logic       irq_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // Read port and output behaviour
  property p_rd_idle;
    !$past(rd_in) |-> rdata_out == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data stray");
  property p_mode_rd;
    rd_in && addr_in == t2c_pkg::OFS_MODE |=> rdata_out[7:2] == 6'h00;
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode bits");
  property p_csel_rd;
    rd_in && addr_in == t2c_pkg::OFS_CLK_SEL |=> rdata_out[7:6] == 2'h0;
  endproperty
  a_csel_rd: assert property (p_csel_rd) else $error("clksel bits");
  property p_unmap;
    rd_in && addr_in == 8'h00 |=> rdata_out == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_rx_one;
    baud_rx_tick_out |=> !baud_rx_tick_out;
  endproperty
  a_rx_one: assert property (p_rx_one) else $error("rx tick long");
  property p_tx_one;
    baud_tx_tick_out |=> !baud_tx_tick_out;
  endproperty
  a_tx_one: assert property (p_tx_one) else $error("tx tick long");
  property p_mask_off;
    wr_in && addr_in == t2c_pkg::OFS_IRQ_MASK && wdata_in == 8'h00
      |-> ##2 !irq_out;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq unmasked");
  property p_rst_quiet;
    $fell(rst_in) |-> !(irq_out | clock_out_out | baud_rx_tick_out
      | baud_tx_tick_out) && rdata_out == 8'h00;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("reset outputs");
  // Main scenarios reached
  c_rx: cover property (baud_rx_tick_out);
  c_tx: cover property (baud_tx_tick_out);
  c_irq: cover property ($rose(irq_out));
endmodule
bind t2c_timer t2c_timer_asserts u_chk
(
  .clk_in           (clk_in),
  .rst_in           (rst_in),
  .addr_in          (addr_in),
  .wdata_in         (wdata_in),
  .wr_in            (wr_in),
  .rd_in            (rd_in),
  .rdata_out        (rdata_out),
  .clock_out_out    (clock_out_out),
  .baud_rx_tick_out (baud_rx_tick_out),
  .baud_tx_tick_out (baud_tx_tick_out),
  .irq_out          (irq_out)
);
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the capture/reload timer.
// Assumes the trigger model drives the pin; the bench tasks drive the register port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk_in, rst_in, wr_in, rd_in, opt_twelve_clk_in, fall;
  logic [7:0] addr_in, wdata_in, rdata_out;
  logic       clock_out_out, baud_rx_tick_out, baud_tx_tick_out, irq_out;
  wire        ext_trigger_pin_in;
  int         rx_ticks = 0;
  int         tx_ticks = 0;
  int         miscompares = 0;
  int         compares = 0;
  t2c_timer dut
  (
    .clk_in             (clk_in),
    .rst_in             (rst_in),
    .addr_in            (addr_in),
    .wdata_in           (wdata_in),
    .wr_in              (wr_in),
    .rd_in              (rd_in),
    .rdata_out          (rdata_out),
    .ext_trigger_pin_in (ext_trigger_pin_in),
    .opt_twelve_clk_in  (opt_twelve_clk_in),
    .clock_out_out      (clock_out_out),
    .baud_rx_tick_out   (baud_rx_tick_out),
    .baud_tx_tick_out   (baud_tx_tick_out),
    .irq_out            (irq_out)
  );
  t2c_trig_model trig
  (
    .clk_in  (clk_in),
    .fall_in (fall),
    .pin_out (ext_trigger_pin_in)
  );
  // Clock and baud tick catcher
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    rx_ticks <= rx_ticks + int'(baud_rx_tick_out);
    tx_ticks <= tx_ticks + int'(baud_tx_tick_out);
  end
  task automatic final_report;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Register port cycles, strobe lowered then one idle edge
  task automatic wr(input logic [7:0] a, d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
    @(posedge clk_in);
  endtask
  task automatic rdc(input logic [7:0] a, e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  task automatic pin_fall;
    fall <= 1'b1;
    @(posedge clk_in);
    fall <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask
  task automatic t_regs;
    rdc(t2c_pkg::OFS_CTRL, 8'h00);
    wr(t2c_pkg::OFS_MODE, 8'hFF);
    rdc(t2c_pkg::OFS_MODE, 8'h03);
    wr(t2c_pkg::OFS_CLK_SEL, 8'hFF);
    rdc(t2c_pkg::OFS_CLK_SEL, 8'h39);
    rdc(8'h00, 8'h00);
    wr(t2c_pkg::OFS_CNT_LO, 8'h5A);
    wr(t2c_pkg::OFS_CNT_HI, 8'hA5);
    rdc(t2c_pkg::OFS_CNT_LO, 8'h5A);
    rdc(t2c_pkg::OFS_CNT_HI, 8'hA5);
    wr(t2c_pkg::OFS_MODE, 8'h00);
    $display("test regs done");
  endtask
  // Divided clock rate over 122 cycles: divider 6, 12, forced 12
  task automatic t_rate;
    logic [7:0] d, ex;
    for (int i = 0; i < 3; i++)
    begin
      opt_twelve_clk_in <= (i == 2);
      ex = (i == 0) ? 8'h14 : 8'h0A;
      wr(t2c_pkg::OFS_CLK_SEL, (i == 1) ? 8'h20 : 8'h00);
      wr(t2c_pkg::OFS_CNT_LO, 8'h00);
      wr(t2c_pkg::OFS_CTRL, 8'h04);
      repeat (120) @(posedge clk_in);
      wr(t2c_pkg::OFS_CTRL, 8'h00);
      rd(t2c_pkg::OFS_CNT_LO, d);
      chk(8'(d + 8'h01 >= ex && d <= ex + 8'h01), 8'h01);
      repeat (20) @(posedge clk_in);
      rdc(t2c_pkg::OFS_CNT_LO, d);
    end
    opt_twelve_clk_in <= 1'b0;
    $display("test rate done");
  endtask
  task automatic t_ovf;
    wr(t2c_pkg::OFS_RCAP_LO, 8'h34);
    wr(t2c_pkg::OFS_RCAP_HI, 8'h12);
    wr(t2c_pkg::OFS_CNT_LO, 8'hFF);
    wr(t2c_pkg::OFS_CNT_HI, 8'hFF);
    wr(t2c_pkg::OFS_MODE, 8'h02);
    wr(t2c_pkg::OFS_IRQ_MASK, 8'h01);
    wr(t2c_pkg::OFS_CTRL, 8'h06);
    pin_fall;
    rdc(t2c_pkg::OFS_CTRL, 8'h86);
    rdc(t2c_pkg::OFS_CNT_LO, 8'h34);
    rdc(t2c_pkg::OFS_CNT_HI, 8'h12);
    #1 chk(8'(irq_out), 8'h01);
    chk(8'(clock_out_out), 8'h01);
    wr(t2c_pkg::OFS_IRQ_MASK, 8'h00);
    #1 chk(8'(irq_out), 8'h00);
    wr(t2c_pkg::OFS_IRQ_MASK, 8'h01);
    #1 chk(8'(irq_out), 8'h01);
    wr(t2c_pkg::OFS_IRQ_STAT, 8'h01);
    #1 chk(8'(irq_out), 8'h00);
    wr(t2c_pkg::OFS_MODE, 8'h00);
    #1 chk(8'(clock_out_out), 8'h00);
    $display("test overflow done");
  endtask
  task automatic t_cap;
    wr(t2c_pkg::OFS_CNT_LO, 8'hCD);
    wr(t2c_pkg::OFS_CNT_HI, 8'hAB);
    wr(t2c_pkg::OFS_CTRL, 8'h09);
    pin_fall;
    rdc(t2c_pkg::OFS_RCAP_LO, 8'hCD);
    rdc(t2c_pkg::OFS_RCAP_HI, 8'hAB);
    rdc(t2c_pkg::OFS_CTRL, 8'h49);
    wr(t2c_pkg::OFS_RCAP_LO, 8'h11);
    wr(t2c_pkg::OFS_CTRL, 8'h08);
    pin_fall;
    rdc(t2c_pkg::OFS_CNT_LO, 8'h11);
    $display("test capture done");
  endtask
  // Baud bits force reload and route ticks, no overflow flag
  task automatic t_baud;
    logic [7:0] b;
    int         r0;
    int         t0;
    wr(t2c_pkg::OFS_RCAP_HI, 8'h43);
    for (int i = 0; i < 2; i++)
    begin
      b = (i == 0) ? 8'h2F : 8'h1F;
      wr(t2c_pkg::OFS_CNT_LO, 8'hFF);
      wr(t2c_pkg::OFS_CNT_HI, 8'hFF);
      wr(t2c_pkg::OFS_CTRL, b);
      r0 = rx_ticks;
      t0 = tx_ticks;
      pin_fall;
      rdc(t2c_pkg::OFS_CNT_HI, 8'h43);
      rdc(t2c_pkg::OFS_CTRL, b);
      chk(8'(rx_ticks - r0), (i == 0) ? 8'h01 : 8'h00);
      chk(8'(tx_ticks - t0), (i == 0) ? 8'h00 : 8'h01);
    end
    $display("test baud done");
  endtask
  task automatic t_down;
    wr(t2c_pkg::OFS_MODE, 8'h01);
    wr(t2c_pkg::OFS_CNT_LO, 8'h10);
    wr(t2c_pkg::OFS_CTRL, 8'h06);
    pin_fall;
    rdc(t2c_pkg::OFS_CNT_LO, 8'h0F);
    wr(t2c_pkg::OFS_CNT_LO, 8'h11);
    pin_fall;
    rdc(t2c_pkg::OFS_CTRL, 8'h86);
    rdc(t2c_pkg::OFS_CNT_HI, 8'hFF);
    $display("test down done");
  endtask
  // Reset, then the scenarios in turn
  initial
  begin
    rst_in = 1'b1;
    {wr_in, rd_in, opt_twelve_clk_in, fall} = 4'h0;
    {addr_in, wdata_in} = 16'h0000;
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    t_regs;
    t_rate;
    t_ovf;
    t_cap;
    t_baud;
    t_down;
    final_report;
  end
  // Watchdog well past the expected run
  initial
  begin
    #200000;
    miscompares++;
    final_report;
  end
endmodule
`default_nettype wire
